//--- atw_analog_trim.sv
// Analog trim register bank with over-current delay select and window watchdog timing.
`timescale 1ns/1ps
`default_nettype none
module atw_analog_trim #(
    parameter int OC_DELAY0_CYC = atw_pkg::OC_DELAY0_CYC,
    parameter int OC_DELAY1_CYC = atw_pkg::OC_DELAY1_CYC,
    parameter int OC_DELAY2_CYC = atw_pkg::OC_DELAY2_CYC,
    parameter int OC_DELAY3_CYC = atw_pkg::OC_DELAY3_CYC,
    parameter int WDOG_PERIOD_CYC = atw_pkg::WDOG_PERIOD_CYC
) (
    // Clock and reset.
    input wire logic mclk,
    input wire logic rst,
    // Register port from the internal serial slave.
    input wire atw_pkg::atw_req_type regReq,
    output logic regAck,
    output logic [7:0] regRdData,
    // Analog control inputs.
    input wire logic currentSenseAlternateSel,
    input wire logic switchedSupplyOcDetect,
    // Watchdog control inputs.
    input wire logic [1:0] watchdogPeriodSel,
    input wire logic watchdogClear,
    // Trim values towards the analog circuits.
    output atw_pkg::atw_trim1_type trim1,
    output atw_pkg::atw_trim2_type trim2,
    output logic signed [4:0] refTrimAdjust,
    output logic refTrimUndefined,
    output logic signed [4:0] bridge12Adjust,
    output logic signed [4:0] bridge34Adjust,
    // Supervision outputs.
    output logic switchedSupplyOcShutdown,
    output logic watchdogWindowOpen,
    output logic watchdogReset
);

    // ------------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------------
    if (OC_DELAY3_CYC < 1 || OC_DELAY0_CYC >= (1 << atw_pkg::OC_CNT_W)) begin : g_ocChk
        $error("Over-current delay counts do not fit the filter counter.");
    end
    if (WDOG_PERIOD_CYC < 16 || WDOG_PERIOD_CYC >= (1 << atw_pkg::WDOG_CNT_W)) begin : g_wdChk
        $error("Watchdog period does not fit the watchdog counter.");
    end

    // ------------------------------------------------------------------
    // Decode functions
    // ------------------------------------------------------------------
    // Reference trim in percent; undefined codes give no adjustment.
    function automatic logic signed [4:0] refPercent(input logic [3:0] code);
        unique case (code)
            4'h0: refPercent = 5'sd0;
            4'h1: refPercent = 5'sd2;
            4'h2: refPercent = 5'sd4;
            4'h3: refPercent = 5'sd8;
            4'h4: refPercent = 5'sd12;
            4'h5: refPercent = -5'sd2;
            4'h6: refPercent = -5'sd4;
            4'h7: refPercent = -5'sd8;
            4'h8: refPercent = -5'sd12;
            default: refPercent = 5'sd0;
        endcase
    endfunction

    // Three-bit recopy trim in percent; the reserved code is treated as zero.
    function automatic logic signed [4:0] recopy3Percent(input logic [2:0] code);
        unique case (code)
            3'h0: recopy3Percent = 5'sd0;
            3'h1: recopy3Percent = -5'sd5;
            3'h2: recopy3Percent = -5'sd10;
            3'h3: recopy3Percent = -5'sd15;
            3'h4: recopy3Percent = 5'sd0;
            3'h5: recopy3Percent = 5'sd5;
            3'h6: recopy3Percent = 5'sd10;
            3'h7: recopy3Percent = 5'sd15;
        endcase
    endfunction

    // Two-bit recopy trim in percent.
    function automatic logic signed [4:0] recopy2Percent(input logic [1:0] code);
        unique case (code)
            2'h0: recopy2Percent = 5'sd0;
            2'h1: recopy2Percent = -5'sd10;
            2'h2: recopy2Percent = 5'sd5;
            2'h3: recopy2Percent = 5'sd10;
        endcase
    endfunction

    // ------------------------------------------------------------------
    // Register bank
    // ------------------------------------------------------------------
    atw_pkg::atw_trim1_type next_trim1;
    atw_pkg::atw_trim2_type next_trim2;
    logic next_regAck;
    logic [7:0] next_regRdData;

    // Read data is the content before any write in the same access, as the
    // serial frame returns the old value. Writes to the test register are dropped
    // so a stray frame cannot push the analog die into a test mode.
    always_comb begin
        next_trim1 = trim1;
        next_trim2 = trim2;
        next_regAck = regReq.wr | regReq.rd;
        next_regRdData = atw_pkg::READ_ZERO;
        unique case (regReq.addr)
            atw_pkg::ADDR_SUPPLY_DELAY_AND_REF_TRIM: begin
                // Only the delay field reads back; trim and reserved bits read zero.
                next_regRdData = {trim1.switchedSupplyOcDelaySel, 6'h00};
                if (regReq.wr) begin
                    next_trim1 = atw_pkg::atw_trim1_type'(regReq.wdata);
                end
            end
            atw_pkg::ADDR_HALF_BRIDGE_RECOPY_TRIM: begin
                next_regRdData = atw_pkg::READ_ZERO;
                if (regReq.wr) begin
                    next_trim2 = atw_pkg::atw_trim2_type'(regReq.wdata);
                end
            end
            default: begin
                next_regRdData = atw_pkg::READ_ZERO;
            end
        endcase
    end

    // Registers of the bank; reset clears every trim field.
    always_ff @(posedge mclk) begin
        if (rst) begin
            trim1 <= atw_pkg::RESET_SUPPLY_DELAY_AND_REF_TRIM;
            trim2 <= atw_pkg::RESET_HALF_BRIDGE_RECOPY_TRIM;
            regAck <= 1'b0;
            regRdData <= atw_pkg::READ_ZERO;
        end else begin
            trim1 <= next_trim1;
            trim2 <= next_trim2;
            regAck <= next_regAck;
            regRdData <= next_regRdData;
        end
    end

    // ------------------------------------------------------------------
    // Trim decode
    // ------------------------------------------------------------------
    logic signed [4:0] next_refTrimAdjust;
    logic next_refTrimUndefined;
    logic signed [4:0] next_bridge12Adjust;
    logic signed [4:0] next_bridge34Adjust;

    // The decoded values trail the register by one cycle. Bridges 3/4 with the
    // alternate select at 0 are trimmed from the third trim register, not here.
    always_comb begin
        next_refTrimAdjust = refPercent(trim1.currentReferenceTrim);
        next_refTrimUndefined = trim1.currentReferenceTrim > atw_pkg::REF_TRIM_MAX_CODE;
        if (currentSenseAlternateSel) begin
            next_bridge12Adjust = recopy3Percent(trim2.bridgeRecopyTrimAlt1[2:0]);
            next_bridge34Adjust = recopy3Percent(trim2.bridgeRecopyTrimAlt1[5:3]);
        end else begin
            next_bridge12Adjust = recopy2Percent(trim2.bridge12RecopyTrimAlt0);
            next_bridge34Adjust = 5'sd0;
        end
    end

    // Decoded trim registers.
    always_ff @(posedge mclk) begin
        if (rst) begin
            refTrimAdjust <= 5'sd0;
            refTrimUndefined <= 1'b0;
            bridge12Adjust <= 5'sd0;
            bridge34Adjust <= 5'sd0;
        end else begin
            refTrimAdjust <= next_refTrimAdjust;
            refTrimUndefined <= next_refTrimUndefined;
            bridge12Adjust <= next_bridge12Adjust;
            bridge34Adjust <= next_bridge34Adjust;
        end
    end

    // ------------------------------------------------------------------
    // Over-current filter
    // ------------------------------------------------------------------
    atw_oc_filter #(
        .DELAY0_CYC(OC_DELAY0_CYC),
        .DELAY1_CYC(OC_DELAY1_CYC),
        .DELAY2_CYC(OC_DELAY2_CYC),
        .DELAY3_CYC(OC_DELAY3_CYC)
    ) u_ocFilter (
        .mclk(mclk),
        .rst(rst),
        .delaySel(trim1.switchedSupplyOcDelaySel),
        .ocDetect(switchedSupplyOcDetect),
        .ocShutdown(switchedSupplyOcShutdown)
    );

    // ------------------------------------------------------------------
    // Window watchdog
    // ------------------------------------------------------------------
    atw_pkg::atw_wdog_state_type wdState;
    atw_pkg::atw_wdog_state_type next_wdState;
    logic [atw_pkg::WDOG_CNT_W-1:0] wdCount;
    logic [atw_pkg::WDOG_CNT_W-1:0] next_wdCount;
    logic [atw_pkg::WDOG_CNT_W-1:0] wdPeriod;
    logic next_watchdogReset;

    // Each select step halves the period; the window opens at half of it.
    // A clear in the closed half or no clear by the period end resets the system.
    always_comb begin
        wdPeriod = atw_pkg::WDOG_CNT_W'(WDOG_PERIOD_CYC) >> watchdogPeriodSel;
        next_wdState = wdState;
        next_wdCount = wdCount + 1'b1;
        next_watchdogReset = 1'b0;
        unique case (wdState)
            atw_pkg::WD_CLOSED: begin
                if (watchdogClear) begin
                    next_watchdogReset = 1'b1;
                    next_wdCount = '0;
                end else if (wdCount == (wdPeriod >> 1) - 1'b1) begin
                    next_wdState = atw_pkg::WD_OPEN;
                end
            end
            atw_pkg::WD_OPEN: begin
                if (watchdogClear) begin
                    next_wdState = atw_pkg::WD_CLOSED;
                    next_wdCount = '0;
                end else if (wdCount >= wdPeriod - 1'b1) begin
                    next_watchdogReset = 1'b1;
                    next_wdState = atw_pkg::WD_CLOSED;
                    next_wdCount = '0;
                end
            end
            default: begin
                next_wdState = atw_pkg::WD_CLOSED;
                next_wdCount = '0;
            end
        endcase
    end

    // Watchdog registers; the window flag is registered from the next state, so it follows the open state.
    always_ff @(posedge mclk) begin
        if (rst) begin
            wdState <= atw_pkg::WD_CLOSED;
            wdCount <= '0;
            watchdogReset <= 1'b0;
            watchdogWindowOpen <= 1'b0;
        end else begin
            wdState <= next_wdState;
            wdCount <= next_wdCount;
            watchdogReset <= next_watchdogReset;
            watchdogWindowOpen <= (next_wdState == atw_pkg::WD_OPEN);
        end
    end

endmodule
`default_nettype wire

//--- atw_pkg.sv
// Package with the register map, field layouts and timing constants of the analog trim block.
package atw_pkg;

    // ------------------------------------------------------------------
    // Register map on the internal register port
    // ------------------------------------------------------------------
    localparam logic [5:0] ADDR_PRODUCTION_TEST = 6'h0E;
    localparam logic [5:0] ADDR_SUPPLY_DELAY_AND_REF_TRIM = 6'h0F;
    localparam logic [5:0] ADDR_HALF_BRIDGE_RECOPY_TRIM = 6'h10;
    localparam logic [7:0] RESET_SUPPLY_DELAY_AND_REF_TRIM = 8'h00;
    localparam logic [7:0] RESET_HALF_BRIDGE_RECOPY_TRIM = 8'h00;
    localparam logic [7:0] READ_ZERO = 8'h00;

    // Field positions of the first trim register.
    localparam int OC_DELAY_SEL_LSB = 6;
    localparam int REF_TRIM_LSB = 0;
    // Highest defined current reference trim code.
    localparam logic [3:0] REF_TRIM_MAX_CODE = 4'h8;
    // Reserved three-bit recopy code.
    localparam logic [2:0] RECOPY_RESERVED_CODE = 3'h4;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int CLK_FREQ_HZ = 20_000_000;
    localparam int CYC_PER_US = CLK_FREQ_HZ / 1_000_000;
    localparam int OC_DELAY0_US = 950;
    localparam int OC_DELAY1_US = 536;
    localparam int OC_DELAY2_US = 234;
    localparam int OC_DELAY3_US = 78;
    localparam int OC_DELAY0_CYC = OC_DELAY0_US * CYC_PER_US;
    localparam int OC_DELAY1_CYC = OC_DELAY1_US * CYC_PER_US;
    localparam int OC_DELAY2_CYC = OC_DELAY2_US * CYC_PER_US;
    localparam int OC_DELAY3_CYC = OC_DELAY3_US * CYC_PER_US;
    localparam int OC_CNT_W = 16;
    // Nominal watchdog period for select code 00; each code step halves it.
    localparam int WDOG_PERIOD_US = 80_000;
    localparam int WDOG_PERIOD_CYC = WDOG_PERIOD_US * CYC_PER_US;
    localparam int WDOG_CNT_W = 24;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [1:0] switchedSupplyOcDelaySel;
        logic [1:0] reservedBits;
        logic [3:0] currentReferenceTrim;
    } atw_trim1_type;

    typedef struct packed {
        logic [1:0] bridge12RecopyTrimAlt0;
        logic [5:0] bridgeRecopyTrimAlt1;
    } atw_trim2_type;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [5:0] addr;
        logic [7:0] wdata;
    } atw_req_type;

    typedef enum logic [1:0] {
        WD_CLOSED = 2'b01,
        WD_OPEN = 2'b10
    } atw_wdog_state_type;

endpackage

//--- atw_oc_filter.sv
// Over-current shutdown filter for the switched supply output with selectable delay.
`timescale 1ns/1ps
`default_nettype none
module atw_oc_filter #(
    parameter int DELAY0_CYC = atw_pkg::OC_DELAY0_CYC,
    parameter int DELAY1_CYC = atw_pkg::OC_DELAY1_CYC,
    parameter int DELAY2_CYC = atw_pkg::OC_DELAY2_CYC,
    parameter int DELAY3_CYC = atw_pkg::OC_DELAY3_CYC
) (
    // Clock and reset.
    input wire logic mclk,
    input wire logic rst,
    // Delay select and raw detector.
    input wire logic [1:0] delaySel,
    input wire logic ocDetect,
    // Filtered shutdown request.
    output logic ocShutdown
);

    // ------------------------------------------------------------------
    // Delay lookup
    // ------------------------------------------------------------------
    logic [atw_pkg::OC_CNT_W-1:0] ocCount;
    logic [atw_pkg::OC_CNT_W-1:0] next_ocCount;
    logic next_ocShutdown;
    logic [atw_pkg::OC_CNT_W-1:0] limit;

    // Code 00 is the longest filter, code 11 the shortest.
    always_comb begin
        unique case (delaySel)
            2'b00: limit = atw_pkg::OC_CNT_W'(DELAY0_CYC);
            2'b01: limit = atw_pkg::OC_CNT_W'(DELAY1_CYC);
            2'b10: limit = atw_pkg::OC_CNT_W'(DELAY2_CYC);
            2'b11: limit = atw_pkg::OC_CNT_W'(DELAY3_CYC);
        endcase
    end

    // ------------------------------------------------------------------
    // Filter counter
    // ------------------------------------------------------------------
    // A glitch shorter than the delay restarts the count, so charging a capacitive
    // load does not trip the output.
    always_comb begin
        next_ocCount = ocCount;
        next_ocShutdown = ocShutdown;
        if (!ocDetect) begin
            next_ocCount = '0;
            next_ocShutdown = 1'b0;
        end else if (ocCount >= limit - 1'b1) begin
            next_ocShutdown = 1'b1;
        end else begin
            next_ocCount = ocCount + 1'b1;
        end
    end

    // Registers of the filter.
    always_ff @(posedge mclk) begin
        if (rst) begin
            ocCount <= '0;
            ocShutdown <= 1'b0;
        end else begin
            ocCount <= next_ocCount;
            ocShutdown <= next_ocShutdown;
        end
    end

endmodule
`default_nettype wire

//--- atw_chk.sv
// Checker of the port relations of the analog trim bank.
`timescale 1ns/1ps
`default_nettype none
module atw_chk #(
    parameter int OC_DELAY0_CYC = 40,
    parameter int OC_DELAY1_CYC = 30,
    parameter int OC_DELAY2_CYC = 20,
    parameter int OC_DELAY3_CYC = 10
) (
    // Clock and reset.
    input wire logic mclk,
    input wire logic rst,
    // Register port.
    input wire atw_pkg::atw_req_type regReq,
    input wire logic regAck,
    input wire logic [7:0] regRdData,
    // Analog and watchdog controls.
    input wire logic currentSenseAlternateSel,
    input wire logic switchedSupplyOcDetect,
    input wire logic [1:0] watchdogPeriodSel,
    input wire logic watchdogClear,
    // Trim and supervision outputs.
    input wire atw_pkg::atw_trim1_type trim1,
    input wire atw_pkg::atw_trim2_type trim2,
    input wire logic signed [4:0] refTrimAdjust,
    input wire logic refTrimUndefined,
    input wire logic signed [4:0] bridge12Adjust,
    input wire logic signed [4:0] bridge34Adjust,
    input wire logic switchedSupplyOcShutdown,
    input wire logic watchdogWindowOpen,
    input wire logic watchdogReset
);
    // Adjustments in percent; undefined and reserved codes give none.
    localparam int REF_TAB [16] = '{0, 2, 4, 8, 12, -2, -4, -8, -12, 0, 0, 0, 0, 0, 0, 0};
    localparam int BR2_TAB [4] = '{0, -10, 5, 10};
    localparam int BR3_TAB [8] = '{0, -5, -10, -15, 0, 5, 10, 15};
    logic [15:0] detCnt;
    logic [15:0] next_detCnt;
    int limit;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    // Saturating run length of the raw detector.
    always_comb begin
        next_detCnt = switchedSupplyOcDetect ? detCnt + {15'h0000, ~&detCnt} : 16'h0000;
    end
    always_ff @(posedge mclk) begin
        detCnt <= rst ? 16'h0000 : next_detCnt;
    end
    // Filter length of the current delay code.
    assign limit = (trim1.switchedSupplyOcDelaySel == 2'h0) ? OC_DELAY0_CYC :
        (trim1.switchedSupplyOcDelaySel == 2'h1) ? OC_DELAY1_CYC :
        (trim1.switchedSupplyOcDelaySel == 2'h2) ? OC_DELAY2_CYC : OC_DELAY3_CYC;

    // A clear while closed that stays closed.
    sequence closedClear;
        watchdogClear && !watchdogWindowOpen ##1 !watchdogWindowOpen;
    endsequence

    AST_RD_TRIM1: assert property (
        regReq.rd && !regReq.wr && regReq.addr == atw_pkg::ADDR_SUPPLY_DELAY_AND_REF_TRIM
        |=> regAck && regRdData == {trim1.switchedSupplyOcDelaySel, 6'h00}) else $error("rd 0F");
    AST_RD_TRIM2: assert property (
        (regReq.rd || regReq.wr) && regReq.addr == atw_pkg::ADDR_HALF_BRIDGE_RECOPY_TRIM
        |=> regAck && regRdData == 8'h00) else $error("rd 10");
    AST_WR_TRIM1: assert property (
        regReq.wr && regReq.addr == atw_pkg::ADDR_SUPPLY_DELAY_AND_REF_TRIM
        |=> trim1 == $past(regReq.wdata)) else $error("wr 0F");
    AST_IGNORED: assert property (
        regReq.wr && regReq.addr != atw_pkg::ADDR_SUPPLY_DELAY_AND_REF_TRIM
        && regReq.addr != atw_pkg::ADDR_HALF_BRIDGE_RECOPY_TRIM
        |=> $stable(trim1) && $stable(trim2)) else $error("ignored wr");
    AST_REF_MAP: assert property (
        refTrimAdjust == REF_TAB[$past(trim1.currentReferenceTrim)]
        && refTrimUndefined == ($past(trim1.currentReferenceTrim) > 4'h8)) else $error("ref");
    AST_BR_MAP: assert property (
        bridge12Adjust == ($past(currentSenseAlternateSel) ?
        BR3_TAB[$past(trim2.bridgeRecopyTrimAlt1[2:0])] :
        BR2_TAB[$past(trim2.bridge12RecopyTrimAlt0)])
        && bridge34Adjust == ($past(currentSenseAlternateSel) ?
        BR3_TAB[$past(trim2.bridgeRecopyTrimAlt1[5:3])] : 0)) else $error("bridge");
    AST_OC_DROP: assert property (
        !switchedSupplyOcDetect |=> !switchedSupplyOcShutdown) else $error("oc drop");
    AST_OC_RISE: assert property (
        $rose(switchedSupplyOcShutdown) |-> detCnt >= limit - 1 && detCnt <= limit + 1)
        else $error("oc delay");
    AST_WD_EARLY: assert property (
        closedClear |-> watchdogReset) else $error("early clear");
    AST_WD_OPEN: assert property (
        watchdogClear && watchdogWindowOpen |=> !watchdogReset) else $error("open clear");
endmodule
`default_nettype wire

//--- atw_mcu_model.sv
// Behavioural model of the microcontroller that drives the register port.
`timescale 1ns/1ps
`default_nettype none
module atw_mcu_model #(
    // Stored trim bytes; the values are arbitrary test patterns.
    parameter logic [7:0] TRIM1_BYTE = 8'h85,
    parameter logic [7:0] TRIM2_BYTE = 8'h6B,
    parameter logic [7:0] TRIM3_BYTE = 8'h3C
) (
    // Clock.
    input wire logic mclk,
    // Answer from the bank.
    input wire logic regAck,
    input wire logic [7:0] regRdData,
    // Requests towards the bank.
    output atw_pkg::atw_req_type regReq,
    output logic watchdogClear
);
    // Idle port at time zero.
    initial begin
        regReq = '0;
        watchdogClear = 1'b0;
    end

    // The bank takes a level at each edge, so a request stands for one edge.
    // Address and data show the inverse afterwards so stale values cannot pass.
    task automatic access(input logic w, input logic [5:0] a, input logic [7:0] d,
        output logic [7:0] q, output logic ack);
        @(posedge mclk);
        #1;
        regReq = '{wr: w, rd: !w, addr: a, wdata: d};
        @(posedge mclk);
        #1;
        ack = regAck;
        q = regRdData;
        regReq = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
    endtask

    // Copy the stored trims in order after a reset; reserved bits stay clear.
    task automatic load_trims;
        logic [7:0] q;
        logic k;
        access(1'b1, 6'h0F, TRIM1_BYTE, q, k);
        access(1'b1, 6'h10, TRIM2_BYTE, q, k);
        access(1'b1, 6'h11, TRIM3_BYTE, q, k);
    endtask

    // One clear pulse, placed by the caller inside the open half or the closed half.
    task automatic wd_clear;
        @(posedge mclk);
        #1;
        watchdogClear = 1'b1;
        @(posedge mclk);
        #1;
        watchdogClear = 1'b0;
    endtask
endmodule
`default_nettype wire

//--- tb.sv
// Self-checking bench of the analog trim bank.
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic currentSenseAlternateSel = 1'b0;
    logic switchedSupplyOcDetect = 1'b0;
    logic [1:0] watchdogPeriodSel = 2'h0;
    atw_pkg::atw_req_type regReq;
    atw_pkg::atw_trim1_type trim1;
    atw_pkg::atw_trim2_type trim2;
    logic watchdogClear, regAck, refTrimUndefined, switchedSupplyOcShutdown;
    logic watchdogWindowOpen, watchdogReset;
    logic [7:0] regRdData;
    logic signed [4:0] refTrimAdjust, bridge12Adjust, bridge34Adjust;
    int n_mismatch = 0;
    int n_compared = 0;
    // Rows: first trim byte and the adjustment it gives.
    logic [7:0] rowW [11] = '{8'h00, 8'h41, 8'h82, 8'hC3, 8'h04, 8'h45, 8'h86, 8'hC7, 8'h08,
        8'h49, 8'h8F};
    int rowAdj [11] = '{0, 2, 4, 8, 12, -2, -4, -8, -12, 0, 0};
    int ocLim [4] = '{40, 30, 20, 10};
    int br2 [4] = '{0, -10, 5, 10};
    int br3 [8] = '{0, -5, -10, -15, 0, 5, 10, 15};

    // Short counts keep the runs brief.
    atw_analog_trim #(.OC_DELAY0_CYC(40), .OC_DELAY1_CYC(30), .OC_DELAY2_CYC(20),
        .OC_DELAY3_CYC(10), .WDOG_PERIOD_CYC(64)) dut (.mclk(mclk), .rst(rst),
        .regReq(regReq), .regAck(regAck), .regRdData(regRdData),
        .currentSenseAlternateSel(currentSenseAlternateSel),
        .switchedSupplyOcDetect(switchedSupplyOcDetect), .watchdogPeriodSel(watchdogPeriodSel),
        .watchdogClear(watchdogClear), .trim1(trim1), .trim2(trim2),
        .refTrimAdjust(refTrimAdjust), .refTrimUndefined(refTrimUndefined),
        .bridge12Adjust(bridge12Adjust), .bridge34Adjust(bridge34Adjust),
        .switchedSupplyOcShutdown(switchedSupplyOcShutdown),
        .watchdogWindowOpen(watchdogWindowOpen), .watchdogReset(watchdogReset));
    atw_mcu_model mcu (.mclk(mclk), .regAck(regAck), .regRdData(regRdData), .regReq(regReq),
        .watchdogClear(watchdogClear));

    // Clock of 50 ns.
    always #25 mclk = ~mclk;

    // Compare and count.
    task automatic check(input string nm, input logic [7:0] exp, input logic [7:0] got);
        n_compared++;
        if (got !== exp) begin
            $display("ERROR %s expected %h seen %h", nm, exp, got);
            n_mismatch++;
        end
    endtask

    // Cycles to the next watchdog pulse and to the opening.
    task automatic wd_span(output int ko, output int k);
        ko = 0;
        k = 0;
        do begin
            @(posedge mclk);
            #1;
            k++;
            if (watchdogWindowOpen === 1'b1 && ko == 0) ko = k;
        end while (watchdogReset !== 1'b1 && k < 300);
    endtask

    task automatic end_of_test;
        $display("compared %0d mismatches %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // Main sequence.
    initial begin
        logic [7:0] q;
        logic k;
        int n;
        int ko;
        int p;
        repeat (5) @(posedge mclk);
        #1;
        rst = 1'b0;
        for (int i = 0; i < 11; i++) begin
            mcu.access(1'b1, 6'h0F, rowW[i], q, k);
            check("ack", 8'h01, {7'h00, k});
            check("old 0F", {(i > 0) ? rowW[i - 1][7:6] : 2'h0, 6'h00}, q);
            @(posedge mclk);
            #1;
            check("trim1", rowW[i], trim1);
            check("ref adjust", 8'(rowAdj[i]), 8'(refTrimAdjust));
            check("ref undefined", {7'h00, i > 8}, {7'h00, refTrimUndefined});
        end
        // Every recopy code under both sense selects.
        for (int b = 0; b < 8; b++) begin
            for (int alt = 0; alt < 2; alt++) begin
                currentSenseAlternateSel = alt[0];
                mcu.access(1'b1, 6'h10, {b[1:0], b[2:0], b[2:0]}, q, k);
                check("old 10", 8'h00, q);
                @(posedge mclk);
                #1;
                check("bridge12", 8'(alt ? br3[b] : br2[b%4]), 8'(bridge12Adjust));
                check("bridge34", 8'(alt ? br3[b] : 0), 8'(bridge34Adjust));
            end
        end
        // Test register, an unused trim address and an unmapped one are ignored.
        foreach (ocLim[j]) begin
            mcu.access(1'b1, (j == 0) ? 6'h0E : (j == 1) ? 6'h11 : 6'h3F, 8'h5A, q, k);
            check("ignored rd", 8'h00, q);
        end
        check("trim1 kept", 8'h8F, trim1);
        check("trim2 kept", 8'hFF, trim2);
        mcu.access(1'b0, 6'h0F, 8'h00, q, k);
        check("rd 0F", 8'h80, q);
        // Reset in mid-run clears the trims, then the stored bytes are reloaded.
        rst = 1'b1;
        repeat (5) @(posedge mclk);
        #1;
        rst = 1'b0;
        check("rst trim1", 8'h00, trim1);
        check("rst trim2", 8'h00, trim2);
        mcu.load_trims();
        check("load trim1", mcu.TRIM1_BYTE, trim1);
        check("load trim2", mcu.TRIM2_BYTE, trim2);
        // Over-current filter length per delay code, then release.
        for (int c = 0; c < 4; c++) begin
            mcu.access(1'b1, 6'h0F, {c[1:0], 6'h00}, q, k);
            switchedSupplyOcDetect = 1'b1;
            n = 0;
            while (switchedSupplyOcShutdown !== 1'b1 && n < 100) begin
                @(posedge mclk);
                #1;
                n++;
            end
            check("oc delay", 8'h01, {7'h00, n >= ocLim[c] && n <= ocLim[c] + 1});
            switchedSupplyOcDetect = 1'b0;
            repeat (2) @(posedge mclk);
            #1;
            check("oc drop", 8'h00, {7'h00, switchedSupplyOcShutdown});
        end
        // Watchdog period and opening per code.
        for (int s = 0; s < 4; s++) begin
            watchdogPeriodSel = s[1:0];
            p = 64 >> s;
            wd_span(ko, n);
            wd_span(ko, n);
            check("wd period", 8'h01, {7'h00, n >= p - 1 && n <= p + 1});
            check("wd open", 8'h01, {7'h00, ko >= p / 2 - 1 && ko <= p / 2 + 1});
        end
        // Clear inside the open half, then a clear in the closed half.
        watchdogPeriodSel = 2'h1;
        n = 0;
        while (watchdogWindowOpen !== 1'b1 && n < 100) begin
            @(posedge mclk);
            #1;
            n++;
        end
        mcu.wd_clear();
        n = 0;
        repeat (3) begin
            @(posedge mclk);
            #1;
            if (watchdogReset === 1'b1) n++;
        end
        check("open clear", 8'h00, 8'(n));
        mcu.wd_clear();
        check("closed clear", 8'h01, {7'h00, watchdogReset});
        end_of_test();
    end

    // Hang guard, far beyond the run length.
    initial begin
        #500_000;
        n_mismatch++;
        end_of_test();
    end
endmodule

bind atw_analog_trim atw_chk #(.OC_DELAY0_CYC(OC_DELAY0_CYC), .OC_DELAY1_CYC(OC_DELAY1_CYC),
    .OC_DELAY2_CYC(OC_DELAY2_CYC), .OC_DELAY3_CYC(OC_DELAY3_CYC)) chk (.mclk(mclk), .rst(rst),
    .regReq(regReq), .regAck(regAck), .regRdData(regRdData),
    .currentSenseAlternateSel(currentSenseAlternateSel),
    .switchedSupplyOcDetect(switchedSupplyOcDetect), .watchdogPeriodSel(watchdogPeriodSel),
    .watchdogClear(watchdogClear), .trim1(trim1), .trim2(trim2), .refTrimAdjust(refTrimAdjust),
    .refTrimUndefined(refTrimUndefined), .bridge12Adjust(bridge12Adjust),
    .bridge34Adjust(bridge34Adjust), .switchedSupplyOcShutdown(switchedSupplyOcShutdown),
    .watchdogWindowOpen(watchdogWindowOpen), .watchdogReset(watchdogReset));
`default_nettype wire
